// ### verilog/via_pkg.sv
// Package: constants for the vectored interrupt arbiter.
package via_pkg;
	// ==========================================================
	// Sizes
	localparam int          VIA_NUM_SRC        = 14;
	localparam int          VIA_PC_W           = 15;
	// ==========================================================
	// Addresses and vector layout
	localparam logic [14:0] VIA_SERVICE_ADDR   = 15'h00FF;
	localparam logic [7:0]  VIA_VEC_BASE_LO    = 8'hE0;
	localparam logic [7:0]  VIA_VEC_TRAP_LO    = 8'hFE;
	localparam logic [7:0]  VIA_BLOCK_LAST     = 8'hFF;
	localparam logic [7:0]  VIA_TRAP_OPCODE    = 8'h00;
	// ==========================================================
	// Timing
	localparam int          VIA_ACK_INSTR_CYC  = 7;
	localparam logic [2:0]  VIA_ACK_LAST       = 3'h6;
	// ==========================================================
	// Reset values
	localparam logic        VIA_GIE_RST        = 1'b0;
	localparam logic [13:0] VIA_EN_RST         = 14'h0000;
	localparam logic [13:0] VIA_PND_RST        = 14'h0000;
	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		VIA_IDLE  = 3'b000,
		VIA_ACK   = 3'b001,
		VIA_VHI   = 3'b010,
		VIA_VLO   = 3'b011,
		VIA_RETURN_FROM_IRQ_INSTRUCTION  = 3'b100
	} via_state_e;
endpackage : via_pkg

// ### verilog/via_prio.sv
// Fixed-rank priority resolver producing the vector low byte.
`timescale 1ns/1ps
module via_prio
	import via_pkg::*;
#(
	parameter int N = VIA_NUM_SRC
) (
	input  wire logic [N-1:0] active_in,
	input  wire logic         trap_in,
	output logic      [7:0]   vec_lo_out,
	output logic              any_out
);
	initial begin
		if (N < 1 || N > 14) begin
			$error("via_prio: N must be 1..14");
		end
	end

	// Source i owns slot E2 + 2*i; higher index means higher rank.
	logic [7:0] slot [N:0];
	assign slot[0] = VIA_VEC_BASE_LO;
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : g_rank
			assign slot[g+1] = active_in[g] ? (VIA_VEC_BASE_LO + 8'(2 * (g + 1))) : slot[g]; // [R3] [R19]
		end
	endgenerate

	assign vec_lo_out = trap_in ? VIA_VEC_TRAP_LO : slot[N]; // [R2] [R20]
	assign any_out    = |active_in;
endmodule : via_prio

// ### verilog/via_arbiter.sv
// Vectored interrupt arbiter: pending, enables, acknowledge and vector select.
//
// What this block does
// R1 - Every interrupt jumps to 00FF.
// R2 - Trap highest, default vector lowest.
// R3 - Fourteen maskable inputs, fixed rank and slot.
// R4 - Maskable sources have enable and pending flag.
// R5 - Pending and enable bits are program writable.
// R6 - Take only if pending, enabled, global, no trap.
// R7 - Decide at instruction start, highest wins.
// R8 - Reset clears pending, enables, global enable.
// R9 - Already-set pending fires when enabled.
// R10 - Wait for next instruction start, after skips.
// R11 - Ack clears global, pushes address, loads 00FF.
// R12 - Acknowledge takes seven instruction cycles.
// R13 - Program setting global enable allows nesting.
// R14 - Return sets global, pops, loads PC.
// R15 - Pending serviced right after return.
// R16 - Vector select jumps through highest active slot.
// R17 - Table at top of block, next if last byte.
// R18 - Vector is 15 bits, high byte first.
// R19 - Lowest rank E0, upward; trap FE.
// R20 - Nothing active uses lowest slot.
// R21 - Priority sampled first cycle, replaces PC low.
// R22 - Trap flag hidden, reset and clear instruction.
// R23 - Trap opcode fetch raises trap; zeros decode.
`timescale 1ns/1ps
module via_arbiter
	import via_pkg::*;
#(
	parameter int N = VIA_NUM_SRC
) (
	input  wire logic               mclk_in,
	input  wire logic               rst_b_in,
	// Peripheral events and program writes to the mapped bits.
	input  wire logic [N-1:0]       src_event_in,
	input  wire logic [N-1:0]       pnd_wr_mask_in,
	input  wire logic [N-1:0]       pnd_wr_data_in,
	input  wire logic [N-1:0]       en_wr_mask_in,
	input  wire logic [N-1:0]       en_wr_data_in,
	input  wire logic               gie_wr_in,
	input  wire logic               gie_wr_data_in,
	// Core sequencer.
	input  wire logic               instr_start_in,
	input  wire logic               skip_pending_in,
	input  wire logic               instr_cycle_in,
	input  wire logic [7:0]         ir_load_data_in,
	input  wire logic               ir_load_in,
	input  wire logic               vis_exec_in,
	input  wire logic               return_from_irq_instruction_exec_in,
	input  wire logic               trap_clear_in,
	input  wire logic [VIA_PC_W-1:0] pc_in,
	input  wire logic [VIA_PC_W-1:0] stack_pop_data_in,
	input  wire logic [7:0]         prog_rd_data_in,
	input  wire logic               prog_rd_valid_in,
	output logic      [N-1:0]       pnd_out,
	output logic      [N-1:0]       en_out,
	output logic                    global_irq_enable_out,
	output logic                    trap_pending_flag_out,
	output logic                    irq_take_out,
	output logic                    busy_out,
	output logic                    stack_push_out,
	output logic      [VIA_PC_W-1:0] stack_push_data_out,
	output logic                    stack_pop_out,
	output logic                    pc_load_out,
	output logic      [VIA_PC_W-1:0] pc_load_data_out,
	output logic                    prog_rd_out,
	output logic      [VIA_PC_W-1:0] prog_rd_addr_out
);
	initial begin
		if (N < 1 || N > 14) begin
			$error("via_arbiter: N must be 1..14");
		end
	end

	// ==========================================================
	// Flags
	logic [N-1:0]  pnd_q;
	logic [N-1:0]  en_q;
	logic          gie_q;
	logic          trap_q;
	logic          in_trap_q;
	via_state_e    state_q;
	logic [2:0]    ack_cnt_q;
	logic [VIA_PC_W-1:0] table_q;
	logic [6:0]    vec_hi_q;
	logic [N-1:0]  active;
	logic          take;
	logic          trap_fetch;
	logic [7:0]    vec_lo;

	assign active     = pnd_q & en_q; // [R4]
	assign trap_fetch = ir_load_in && (ir_load_data_in == VIA_TRAP_OPCODE); // [R23]
	// Skips finish first: the core raises the start strobe on the next executed instruction.
	assign take = (state_q == VIA_IDLE) && instr_start_in && !skip_pending_in // [R7] [R10]
		&& gie_q && !in_trap_q && (|active); // [R6] [R9] [R15]

	// ==========================================================
	// Pending flags: a hardware set beats a program clear in the same cycle.
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : g_src
			always_ff @(posedge mclk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					pnd_q[g] <= VIA_PND_RST[g]; // [R8]
				end else if (src_event_in[g]) begin
					pnd_q[g] <= 1'b1; // [R4]
				end else if (pnd_wr_mask_in[g]) begin
					pnd_q[g] <= pnd_wr_data_in[g]; // [R5]
				end
			end

			always_ff @(posedge mclk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					en_q[g] <= VIA_EN_RST[g]; // [R8]
				end else if (en_wr_mask_in[g]) begin
					en_q[g] <= en_wr_data_in[g]; // [R5]
				end
			end
		end
	endgenerate

	// ==========================================================
	// Global enable
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			gie_q <= VIA_GIE_RST; // [R8]
		end else if (take) begin
			gie_q <= 1'b0; // [R11]
		end else if (return_from_irq_instruction_exec_in && state_q == VIA_IDLE) begin
			gie_q <= 1'b1; // [R14]
		end else if (gie_wr_in) begin
			gie_q <= gie_wr_data_in; // [R13]
		end
	end

	// ==========================================================
	// Software trap flag and trap service tracking
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			trap_q <= 1'b0; // [R22]
		end else if (trap_fetch) begin
			trap_q <= 1'b1; // [R23]
		end else if (trap_clear_in) begin
			trap_q <= 1'b0; // [R22]
		end
	end

	// Maskable sources wait while a trap is being serviced; it ends at return.
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			in_trap_q <= 1'b0;
		end else if (trap_fetch) begin
			in_trap_q <= 1'b1; // [R6]
		end else if (return_from_irq_instruction_exec_in && state_q == VIA_IDLE) begin
			in_trap_q <= 1'b0;
		end
	end

	// ==========================================================
	// Priority
	via_prio #(
		.N(N)
	) u_prio (
		.active_in  (active),
		.trap_in    (trap_q),
		.vec_lo_out (vec_lo),
		.any_out    ()
	);

	// ==========================================================
	// Sequencer
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q   <= VIA_IDLE;
			ack_cnt_q <= 3'h0;
			table_q   <= '0;
			vec_hi_q  <= 7'h00;
		end else begin
			case (state_q)
				VIA_IDLE: begin
					ack_cnt_q <= 3'h0;
					if (take) begin
						state_q <= VIA_ACK;
					end else if (vis_exec_in) begin
						// Slot chosen in the first cycle of vector select. [R16] [R21]
						if (pc_in[7:0] == VIA_BLOCK_LAST) begin
							table_q <= {7'(pc_in[14:8] + 7'h01), vec_lo}; // [R17]
						end else begin
							table_q <= {pc_in[14:8], vec_lo}; // [R17] [R21]
						end
						state_q <= VIA_VHI;
					end else if (return_from_irq_instruction_exec_in) begin
						state_q <= VIA_RETURN_FROM_IRQ_INSTRUCTION;
					end
				end
				VIA_ACK: begin
					if (instr_cycle_in) begin
						if (ack_cnt_q == VIA_ACK_LAST) begin
							state_q <= VIA_IDLE; // [R12]
						end else begin
							ack_cnt_q <= ack_cnt_q + 3'h1;
						end
					end
				end
				VIA_VHI: begin
					if (prog_rd_valid_in) begin
						vec_hi_q <= prog_rd_data_in[6:0]; // [R18]
						table_q  <= table_q + 15'h0001;
						state_q  <= VIA_VLO;
					end
				end
				VIA_VLO: begin
					if (prog_rd_valid_in) begin
						state_q <= VIA_IDLE;
					end
				end
				VIA_RETURN_FROM_IRQ_INSTRUCTION: begin
					state_q <= VIA_IDLE;
				end
				default: begin
					state_q <= VIA_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Core-facing strobes
	always_comb begin
		stack_push_out   = 1'b0;
		stack_pop_out    = 1'b0;
		pc_load_out      = 1'b0;
		pc_load_data_out = VIA_SERVICE_ADDR;
		prog_rd_out      = 1'b0;
		case (state_q)
			VIA_ACK: begin
				if (instr_cycle_in && ack_cnt_q == VIA_ACK_LAST) begin
					stack_push_out = 1'b1; // [R11]
					pc_load_out    = 1'b1; // [R1] [R11]
				end
			end
			VIA_VHI: begin
				prog_rd_out = 1'b1;
			end
			VIA_VLO: begin
				prog_rd_out = 1'b1;
				if (prog_rd_valid_in) begin
					pc_load_out      = 1'b1; // [R16] [R18]
					pc_load_data_out = {vec_hi_q, prog_rd_data_in};
				end
			end
			VIA_RETURN_FROM_IRQ_INSTRUCTION: begin
				stack_pop_out    = 1'b1; // [R14]
				pc_load_out      = 1'b1;
				pc_load_data_out = stack_pop_data_in;
			end
			default: begin
				pc_load_out = 1'b0;
			end
		endcase
	end

	assign stack_push_data_out   = pc_in; // [R11]
	assign prog_rd_addr_out      = table_q;
	assign irq_take_out          = take;
	assign busy_out              = (state_q != VIA_IDLE);
	assign pnd_out               = pnd_q;
	assign en_out                = en_q;
	assign global_irq_enable_out = gie_q;
	assign trap_pending_flag_out = trap_q;
endmodule : via_arbiter

// ### verif/via_arbiter_assertions.sv
// Concurrent checks on the ports of the vectored interrupt arbiter.
`timescale 1ns/1ps
module via_arbiter_assertions
	import via_pkg::*;
#(
	parameter int N = VIA_NUM_SRC
) (
	input	wire logic		mclk_in,
	input	wire logic		rst_b_in,
	input	wire logic		instr_start_in,
	input	wire logic		skip_pending_in,
	input	wire logic		instr_cycle_in,
	input	wire logic		vis_exec_in,
	input	wire logic		return_from_irq_instruction_exec_in,
	input	wire logic [14:0]	pc_in,
	input	wire logic [14:0]	stack_pop_data_in,
	input	wire logic [N-1:0]	pnd_out,
	input	wire logic [N-1:0]	en_out,
	input	wire logic		global_irq_enable_out,
	input	wire logic		trap_pending_flag_out,
	input	wire logic		irq_take_out,
	input	wire logic		busy_out,
	input	wire logic		stack_push_out,
	input	wire logic [14:0]	stack_push_data_out,
	input	wire logic		stack_pop_out,
	input	wire logic		pc_load_out,
	input	wire logic [14:0]	pc_load_data_out,
	input	wire logic [14:0]	prog_rd_addr_out
);
	// ==========================================================
	// Helper logic
	// Counts instruction cycles after a take, so the push can be pinned to the seventh.
	logic [3:0] cyc_q;
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			cyc_q <= 4'h0;
		else if (irq_take_out)
			cyc_q <= 4'h0;
		else if (busy_out && instr_cycle_in)
			cyc_q <= cyc_q + 4'h1;
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	// ==========================================================
	// Properties
	a_push_service: assert property (stack_push_out |-> pc_load_out && stack_push_data_out == pc_in
		&& pc_load_data_out == VIA_SERVICE_ADDR) else $error("push without service load");
	a_push_seventh: assert property (stack_push_out |-> instr_cycle_in && cyc_q == 4'h6)
		else $error("push not on seventh cycle");
	a_take_clears_gie: assert property (irq_take_out |=> !global_irq_enable_out)
		else $error("global enable kept after take");
	a_take_qualified: assert property (irq_take_out |-> instr_start_in && !skip_pending_in
		&& global_irq_enable_out && !busy_out && (pnd_out & en_out) != '0) else $error("bad take");
	a_return_from_irq_instruction_restore: assert property (return_from_irq_instruction_exec_in && !busy_out && !irq_take_out && !vis_exec_in
		|=> stack_pop_out && pc_load_out
		&& pc_load_data_out == stack_pop_data_in && global_irq_enable_out) else $error("bad return");
	a_vis_trap_slot: assert property (vis_exec_in && !busy_out && !irq_take_out && trap_pending_flag_out
		|=> prog_rd_addr_out[7:0] == VIA_VEC_TRAP_LO) else $error("trap slot missed");
	a_vis_default: assert property (vis_exec_in && !busy_out && !irq_take_out && !trap_pending_flag_out
		&& (pnd_out & en_out) == '0 |=> prog_rd_addr_out[7:0] == VIA_VEC_BASE_LO)
		else $error("default slot missed");
	a_reset_clear: assert property (@(posedge mclk_in) disable iff (1'b0) !rst_b_in
		|-> pnd_out == '0 && en_out == '0 && !global_irq_enable_out) else $error("reset not clear");
endmodule : via_arbiter_assertions

// ### verif/via_core_model.sv
// Core-side partner: instruction cycle pulses and program memory answers.
`timescale 1ns/1ps
module via_core_model (
	input	wire logic		mclk_in,
	input	wire logic		rst_b_in,
	input	wire logic		slow_in,
	input	wire logic		prog_rd_in,
	input	wire logic [14:0]	prog_rd_addr_in,
	output	logic [7:0]		prog_rd_data_out,
	output	logic			prog_rd_valid_out,
	output	logic			instr_cycle_out
);
	// ==========================================================
	// Memory answers
	logic [1:0] wait_q;
	logic [7:0] last_q;
	// Outside the valid cycle the data toggles, so a late sample reads garbage.
	// The answer mixes in the block number, so a wrong table block is seen.
	assign prog_rd_data_out = prog_rd_valid_out ? (prog_rd_addr_in[7:0] ^ {1'b1, prog_rd_addr_in[14:8]})
		: ~last_q;
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wait_q <= 2'h0;
			last_q <= 8'h00;
			prog_rd_valid_out <= 1'b0;
			instr_cycle_out <= 1'b0;
		end else begin
			instr_cycle_out <= ~instr_cycle_out;
			last_q <= prog_rd_data_out;
			prog_rd_valid_out <= prog_rd_in && !prog_rd_valid_out && wait_q >= {slow_in, 1'b0};
			wait_q <= (prog_rd_in && !prog_rd_valid_out) ? wait_q + 2'h1 : 2'h0;
		end
	end
endmodule : via_core_model

// ### verif/via_arbiter_tb_top.sv
// Self-checking bench for the vectored interrupt arbiter.
`timescale 1ns/1ps
module via_arbiter_tb_top
	import via_pkg::*;
;
	logic		mclk_in = '0, rst_b_in = 1'b1, instr_start_in = '0, skip_pending_in = '0;
	logic		gie_wr_in = '0, gie_wr_data_in = '0, ir_load_in = '0, vis_exec_in = '0;
	logic		return_from_irq_instruction_exec_in = '0, trap_clear_in = '0, slow = '0;
	logic [13:0]	src_event_in = '0, pnd_wr_mask_in = '0, pnd_wr_data_in = '0, pm, em;
	logic [13:0]	en_wr_mask_in = '0, en_wr_data_in = '0, pnd_out, en_out;
	logic [14:0]	pc_in = '0, stack_pop_data_in = '0, stack_push_data_out, pc_load_data_out;
	logic [14:0]	prog_rd_addr_out;
	logic [7:0]	ir_load_data_in = '0, prog_rd_data_in;
	logic		instr_cycle_in, prog_rd_valid_in, prog_rd_out, global_irq_enable_out;
	logic		trap_pending_flag_out, irq_take_out, busy_out, stack_push_out;
	logic		stack_pop_out, pc_load_out;
	int		fails = 0, check_count = 0, cyc = 0;
	logic [31:0]	rnd = 32'h0939;
	via_arbiter #(.N(14)) dut (.*);
	via_core_model partner (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .slow_in(slow),
		.prog_rd_in(prog_rd_out), .prog_rd_addr_in(prog_rd_addr_out),
		.prog_rd_data_out(prog_rd_data_in), .prog_rd_valid_out(prog_rd_valid_in),
		.instr_cycle_out(instr_cycle_in));
	always #12.5 mclk_in = ~mclk_in;
	// A hang is cut at a cycle ceiling well above the fewer than two hundred cycles needed.
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			summarize();
		end
	end
	// ==========================================================
	// Tasks
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	task automatic chk(string nm, logic [14:0] exp, logic [14:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	function automatic logic [31:0] nxt(logic [31:0] r);
		return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
	endfunction : nxt
	function automatic logic [14:0] target(logic [14:0] pc, bit trap);
		logic [7:0] s;
		logic [7:0] k;
		s = 8'hE0;
		k = {1'b1, 7'(pc[14:8] + 7'(pc[7:0] == 8'hFF))};
		for (int i = 0; i < 14; i++)
			if (pm[i] && em[i])
				s = 8'hE2 + 8'(2 * i);
		if (trap)
			s = 8'hFE;
		return {s[6:0] ^ k[6:0], {s[7:1], 1'b1} ^ k};
	endfunction : target
	task automatic wait_hi(ref logic s);
		for (int i = 0; i < 60 && s !== 1'b1; i++)
			@(negedge mclk_in);
	endtask : wait_hi
	task automatic wr(logic [13:0] p, logic [13:0] e, logic g);
		{pnd_wr_mask_in, en_wr_mask_in, gie_wr_in} = '1;
		{pnd_wr_data_in, en_wr_data_in, gie_wr_data_in} = {p, e, g};
		{pm, em} = {p, e};
		@(negedge mclk_in);
		{pnd_wr_mask_in, en_wr_mask_in, gie_wr_in} = '0;
	endtask : wr
	task automatic take(logic [14:0] pc);
		pc_in = pc;
		instr_start_in = 1'b1;
		#1 chk("take", 1, irq_take_out);
		@(negedge mclk_in);
		instr_start_in = 1'b0;
		chk("busy", 1, busy_out);
		wait_hi(stack_push_out);
		chk("push", 1, stack_push_out);
		chk("pushed", pc, stack_push_data_out);
		chk("service", VIA_SERVICE_ADDR, pc_load_data_out);
		chk("gie", 0, global_irq_enable_out);
		chk("kept", pm, pnd_out);
		@(negedge mclk_in);
	endtask : take
	task automatic vector_select_instruction(logic [14:0] pc, bit trap);
		pc_in = pc;
		vis_exec_in = 1'b1;
		@(negedge mclk_in);
		vis_exec_in = 1'b0;
		wait_hi(pc_load_out);
		chk("vector", target(pc, trap), pc_load_data_out);
	endtask : vector_select_instruction
	// ==========================================================
	// Scenarios
	initial begin
		rst_b_in = 1'b0;
		repeat (5) @(negedge mclk_in);
		rst_b_in = 1'b1;
		chk("reset", 0, {pnd_out, global_irq_enable_out});
		chk("enables", 0, {en_out, trap_pending_flag_out});
		rnd = nxt(rnd);
		src_event_in = rnd[13:0] | 14'h0001;
		pm = src_event_in;
		@(negedge mclk_in);
		src_event_in = '0;
		chk("pending", pm, pnd_out);
		wr(pm, rnd[29:16] | 14'h0001, 1'b1);
		chk("enables", em, en_out);
		skip_pending_in = 1'b1;
		instr_start_in = 1'b1;
		#1 chk("skipped", 0, irq_take_out);
		@(negedge mclk_in);
		skip_pending_in = 1'b0;
		take(15'h1234);
		for (int k = 0; k < 8; k++) begin
			rnd = nxt(rnd);
			slow = rnd[31];
			wr(k == 0 ? 14'h0 : rnd[13:0], rnd[29:16], 1'b0);
			vector_select_instruction({rnd[22:16], k == 1 ? 8'hFF : rnd[31:24]}, 0);
		end
		wr(14'h0008, 14'h0008, 1'b1);
		chk("nested", 1, global_irq_enable_out);
		take(15'h0200);
		stack_pop_data_in = 15'h0ABC;
		return_from_irq_instruction_exec_in = 1'b1;
		@(negedge mclk_in);
		return_from_irq_instruction_exec_in = 1'b0;
		chk("popped", 15'h0ABC, pc_load_out ? pc_load_data_out : 15'h0);
		chk("pop", 1, stack_pop_out);
		chk("gie", 1, global_irq_enable_out);
		@(negedge mclk_in);
		take(15'h0ABC);
		ir_load_data_in = VIA_TRAP_OPCODE;
		ir_load_in = 1'b1;
		@(negedge mclk_in);
		ir_load_in = 1'b0;
		chk("trap", 1, trap_pending_flag_out);
		vector_select_instruction(15'h01FF, 1);
		trap_clear_in = 1'b1;
		@(negedge mclk_in);
		trap_clear_in = 1'b0;
		chk("trap", 0, trap_pending_flag_out);
		summarize();
	end
endmodule : via_arbiter_tb_top
bind via_arbiter via_arbiter_assertions #(.N(N)) u_chk (.*);
